// file: core/rbt_top.sv
// registered 18-bit bus transceiver core, two directions with bus hold
// assumes all pin inputs are synchronous to mclk; the bench resolves the wires
//
// Functional notes
// RL1: carry 18 bits each way, never inverted
// RL2: transparent high passes A straight to B
// RL3: transparent low, static clock: hold word
// RL4: gate low: capture A on clock rise
// RL5: enable low drives B outputs
// RL6: enable high floats all B outputs
// RL7: gate high ignores clock edges, keeps word
// RL8: transparent active high, clock rising edge
// RL9: B-to-A path mirrors A-to-B exactly
// RL10: bus hold keeps floating inputs' last level
// RL11: storage runs regardless of output enable
module rbt_top
(
   // clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // a side pins
   input wire logic [rbt_pkg::RBT_W-1:0] a_side_bit_i,
   output logic [rbt_pkg::RBT_W-1:0] a_side_bit_o,
   output logic a_side_bit_oe,
   input wire logic a_side_ext_drive,
   output logic [rbt_pkg::RBT_W-1:0] a_side_hold,
   // b side pins
   input wire logic [rbt_pkg::RBT_W-1:0] b_side_bit_i,
   output logic [rbt_pkg::RBT_W-1:0] b_side_bit_o,
   output logic b_side_bit_oe,
   input wire logic b_side_ext_drive,
   output logic [rbt_pkg::RBT_W-1:0] b_side_hold,
   // a to b controls
   input wire logic a_to_b_output_enable_n,
   input wire logic a_to_b_transparent_en,
   input wire logic a_to_b_capture_clk,
   input wire logic a_to_b_clk_gate_n,
   // b to a controls
   input wire logic b_to_a_output_enable_n,
   input wire logic b_to_a_transparent_en,
   input wire logic b_to_a_capture_clk,
   input wire logic b_to_a_clk_gate_n,
   // captured a to b words
   output logic [rbt_pkg::RBT_W-1:0] ab_cap_word,
   output logic ab_cap_valid,
   input wire logic ab_cap_ready,
   output logic ab_cap_fifo_ready
);
   import rbt_pkg::*;

   logic ab_cap_stb;
   logic ba_cap_stb;

   // bus hold: follow the wire while someone drives it, else keep last level
   wire a_driven = a_side_ext_drive | a_side_bit_oe;
   wire b_driven = b_side_ext_drive | b_side_bit_oe;
   wire [RBT_W-1:0] a_eff = a_driven ? a_side_bit_i : a_side_hold; // RL10
   wire [RBT_W-1:0] b_eff = b_driven ? b_side_bit_i : b_side_hold; // RL10

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         a_side_hold <= RBT_WORD_RST;
         b_side_hold <= RBT_WORD_RST;
      end else begin
         a_side_hold <= a_eff;
         b_side_hold <= b_eff;
      end
   end

   // a to b direction
   rbt_path u_ab (
      .mclk(mclk),
      .rst_n(rst_n),
      .din(a_eff),
      .transparent_en(a_to_b_transparent_en),
      .capture_clk(a_to_b_capture_clk),
      .clk_gate_n(a_to_b_clk_gate_n),
      .output_enable_n(a_to_b_output_enable_n),
      .dout_q(b_side_bit_o),
      .oe_q(b_side_bit_oe),
      .cap_stb(ab_cap_stb)
   );

   // b to a direction, same element
   rbt_path u_ba ( // RL9
      .mclk(mclk),
      .rst_n(rst_n),
      .din(b_eff),
      .transparent_en(b_to_a_transparent_en),
      .capture_clk(b_to_a_capture_clk),
      .clk_gate_n(b_to_a_clk_gate_n),
      .output_enable_n(b_to_a_output_enable_n),
      .dout_q(a_side_bit_o),
      .oe_q(a_side_bit_oe),
      .cap_stb(ba_cap_stb)
   );

   // log of words captured a to b
   rbt_fifo #(
      .W(RBT_W),
      .DEPTH(RBT_FIFO_DEPTH),
      .AW(RBT_FIFO_AW)
   ) u_ab_log (
      .mclk(mclk),
      .rst_n(rst_n),
      .in_valid(ab_cap_stb),
      .in_ready(ab_cap_fifo_ready),
      .in_data(a_eff),
      .out_valid(ab_cap_valid),
      .out_ready(ab_cap_ready),
      .out_data(ab_cap_word)
   );

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);

   property p_rl1;
      (a_to_b_transparent_en && !a_to_b_output_enable_n)
         |=> (b_side_bit_oe && b_side_bit_o == $past(a_eff));
   endproperty
   a_rl1: assert property (p_rl1) else $error("b side word differs from a side"); // RL1

   property p_rl2;
      a_to_b_transparent_en |=> b_side_bit_o == $past(a_eff);
   endproperty
   a_rl2: assert property (p_rl2) else $error("transparent mode did not pass a"); // RL2

   property p_rl3;
      (!a_to_b_transparent_en && !ab_cap_stb) ##1 (!a_to_b_transparent_en && !ab_cap_stb)
         |=> $stable(b_side_bit_o);
   endproperty
   a_rl3: assert property (p_rl3) else $error("held word changed"); // RL3

   property p_rl4;
      ($past(rst_n) && !a_to_b_transparent_en && !a_to_b_clk_gate_n
         && a_to_b_capture_clk && !$past(a_to_b_capture_clk))
         |=> b_side_bit_o == $past(a_eff);
   endproperty
   a_rl4: assert property (p_rl4) else $error("rising clock did not capture a"); // RL4

   property p_rl5;
      !a_to_b_output_enable_n |=> b_side_bit_oe;
   endproperty
   a_rl5: assert property (p_rl5) else $error("b outputs not driven"); // RL5

   property p_rl6;
      a_to_b_output_enable_n |=> !b_side_bit_oe;
   endproperty
   a_rl6: assert property (p_rl6) else $error("b outputs driven while disabled"); // RL6

   property p_rl7;
      (!a_to_b_transparent_en && a_to_b_clk_gate_n) [*2] |=> $stable(b_side_bit_o);
   endproperty
   a_rl7: assert property (p_rl7) else $error("gated clock changed the word"); // RL7

   property p_rl8;
      !a_to_b_transparent_en ##1 (!a_to_b_transparent_en && !a_to_b_capture_clk)
         |=> $stable(b_side_bit_o);
   endproperty
   a_rl8: assert property (p_rl8) else $error("low clock level changed the word"); // RL8

   property p_rl9;
      b_to_a_transparent_en |=> a_side_bit_o == $past(b_eff);
   endproperty
   a_rl9: assert property (p_rl9) else $error("b to a transparent failed"); // RL9

   property p_rl10;
      (!a_side_ext_drive && !a_side_bit_oe) |=> a_side_hold == $past(a_side_hold);
   endproperty
   a_rl10: assert property (p_rl10) else $error("floating a input not held"); // RL10

   property p_rl11;
      (a_to_b_output_enable_n && a_to_b_transparent_en) |=> b_side_bit_o == $past(a_eff);
   endproperty
   a_rl11: assert property (p_rl11) else $error("storage stalled while disabled"); // RL11

   property p_rl1_ba;
      (b_to_a_transparent_en && !b_to_a_output_enable_n)
         |=> (a_side_bit_oe && a_side_bit_o == $past(b_eff));
   endproperty
   a_rl1_ba: assert property (p_rl1_ba) else $error("a side word differs from b side"); // RL1

   property p_rl2_gate_ab;
      (a_to_b_transparent_en && a_to_b_clk_gate_n)
         |=> b_side_bit_o == $past(a_eff);
   endproperty
   a_rl2_gate_ab: assert property (p_rl2_gate_ab) else $error("gate blocked transparent a"); // RL2

   property p_rl2_gate_ba;
      (b_to_a_transparent_en && b_to_a_clk_gate_n)
         |=> a_side_bit_o == $past(b_eff);
   endproperty
   a_rl2_gate_ba: assert property (p_rl2_gate_ba) else $error("gate blocked transparent b"); // RL9

   property p_rl3_ba;
      (!b_to_a_transparent_en && !ba_cap_stb) ##1 (!b_to_a_transparent_en && !ba_cap_stb)
         |=> $stable(a_side_bit_o);
   endproperty
   a_rl3_ba: assert property (p_rl3_ba) else $error("held b to a word changed"); // RL3 RL9

   property p_rl4_ba;
      ($past(rst_n) && !b_to_a_transparent_en && !b_to_a_clk_gate_n
         && b_to_a_capture_clk && !$past(b_to_a_capture_clk))
         |=> a_side_bit_o == $past(b_eff);
   endproperty
   a_rl4_ba: assert property (p_rl4_ba) else $error("rising clock did not capture b"); // RL4 RL9

   property p_rl5_ba;
      !b_to_a_output_enable_n |=> a_side_bit_oe;
   endproperty
   a_rl5_ba: assert property (p_rl5_ba) else $error("a outputs not driven"); // RL5 RL9

   property p_rl6_ba;
      b_to_a_output_enable_n |=> !a_side_bit_oe;
   endproperty
   a_rl6_ba: assert property (p_rl6_ba) else $error("a outputs driven while disabled"); // RL6 RL9

   property p_rl7_ba;
      (!b_to_a_transparent_en && b_to_a_clk_gate_n) [*2]
         |=> $stable(a_side_bit_o);
   endproperty
   a_rl7_ba: assert property (p_rl7_ba) else $error("gated b clock changed the word"); // RL7 RL9

   property p_rl7_rise_ab;
      (!a_to_b_transparent_en && a_to_b_clk_gate_n && a_to_b_capture_clk
         && !$past(a_to_b_capture_clk)) |=> $stable(b_side_bit_o);
   endproperty
   a_rl7_rise_ab: assert property (p_rl7_rise_ab) else $error("gated a edge was taken"); // RL7

   property p_rl7_rise_ba;
      (!b_to_a_transparent_en && b_to_a_clk_gate_n && b_to_a_capture_clk
         && !$past(b_to_a_capture_clk)) |=> $stable(a_side_bit_o);
   endproperty
   a_rl7_rise_ba: assert property (p_rl7_rise_ba) else $error("gated b edge was taken"); // RL9

   property p_rl8_ba;
      !b_to_a_transparent_en ##1 (!b_to_a_transparent_en && !b_to_a_capture_clk)
         |=> $stable(a_side_bit_o);
   endproperty
   a_rl8_ba: assert property (p_rl8_ba) else $error("low b clock changed the word"); // RL8 RL9

   property p_rl8_fall_ab;
      (!a_to_b_transparent_en && !a_to_b_capture_clk && $past(a_to_b_capture_clk))
         |=> $stable(b_side_bit_o);
   endproperty
   a_rl8_fall_ab: assert property (p_rl8_fall_ab) else $error("falling a clock captured"); // RL8

   property p_rl8_fall_ba;
      (!b_to_a_transparent_en && !b_to_a_capture_clk && $past(b_to_a_capture_clk))
         |=> $stable(a_side_bit_o);
   endproperty
   a_rl8_fall_ba: assert property (p_rl8_fall_ba) else $error("falling b clock captured"); // RL9

   property p_rl10_b;
      (!b_side_ext_drive && !b_side_bit_oe)
         |=> b_side_hold == $past(b_side_hold);
   endproperty
   a_rl10_b: assert property (p_rl10_b) else $error("floating b input not held"); // RL10

   property p_rl10_a_drv;
      a_side_ext_drive
         |=> a_side_hold == $past(a_side_bit_i);
   endproperty
   a_rl10_a_drv: assert property (p_rl10_a_drv) else $error("a keeper ignored driven wire"); // RL10

   property p_rl10_b_drv;
      b_side_ext_drive
         |=> b_side_hold == $past(b_side_bit_i);
   endproperty
   a_rl10_b_drv: assert property (p_rl10_b_drv) else $error("b keeper ignored driven wire"); // RL10

   property p_rl11_ba;
      (b_to_a_output_enable_n && b_to_a_transparent_en)
         |=> a_side_bit_o == $past(b_eff);
   endproperty
   a_rl11_ba: assert property (p_rl11_ba) else $error("b storage stalled while disabled"); // RL11

   property p_rl11_cap_ab;
      (a_to_b_output_enable_n && ab_cap_stb)
         |=> b_side_bit_o == $past(a_eff);
   endproperty
   a_rl11_cap_ab: assert property (p_rl11_cap_ab) else $error("disabled a capture lost"); // RL11

   property p_rl11_cap_ba;
      (b_to_a_output_enable_n && ba_cap_stb)
         |=> a_side_bit_o == $past(b_eff);
   endproperty
   a_rl11_cap_ba: assert property (p_rl11_cap_ba) else $error("disabled b capture lost"); // RL11

   property p_log_fill;
      (ab_cap_stb && ab_cap_fifo_ready)
         |=> ##1 ab_cap_valid;
   endproperty
   a_log_fill: assert property (p_log_fill) else $error("logged capture never offered"); // RL4

   property p_log_stall;
      (ab_cap_valid && !ab_cap_ready)
         |=> (ab_cap_valid && $stable(ab_cap_word));
   endproperty
   a_log_stall: assert property (p_log_stall) else $error("offered log word dropped"); // RL4

   property p_log_full;
      (!ab_cap_fifo_ready && ab_cap_valid && !ab_cap_ready)
         |=> !ab_cap_fifo_ready;
   endproperty
   a_log_full: assert property (p_log_full) else $error("full log reported room"); // RL4
endmodule : rbt_top

// file: core/rbt_pkg.sv
// constants shared by the registered bus transceiver core
// assumes one 20 MHz clock and synchronous pin inputs
package rbt_pkg;
   localparam int RBT_W = 18;
   localparam int RBT_FIFO_DEPTH = 8;
   localparam int RBT_FIFO_AW = 3;
   localparam logic [RBT_W-1:0] RBT_WORD_RST = 18'h00000;
   localparam logic RBT_CAP_PREV_RST = 1'b1;
   localparam logic RBT_OE_RST = 1'b0;
   localparam real RBT_CLK_PERIOD_NS = 50.0;
endpackage : rbt_pkg

// file: core/rbt_fifo.sv
// capture fifo with registered output stage and registered ready
// assumes depth is a power of two matching the pointer width
module rbt_fifo #(
   parameter int W = 18,
   parameter int DEPTH = 8,
   parameter int AW = 3
) (
   // clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   // drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   logic [W-1:0] mem_q [DEPTH];
   logic [AW-1:0] wr_q;
   logic [AW-1:0] rd_q;
   logic [AW:0] cnt_q;
   logic [AW:0] cnt_d;
   wire push = in_valid & in_ready;
   wire pop = (cnt_q != '0) & (~out_valid | out_ready);
   assign cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

   always_ff @(posedge mclk) begin
      if (push) begin
         mem_q[wr_q] <= in_data;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
         in_ready <= 1'b0;
         out_valid <= 1'b0;
         out_data <= '0;
      end else begin
         cnt_q <= cnt_d;
         in_ready <= (cnt_d < DEPTH[AW:0]);
         if (push) begin
            wr_q <= wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= rd_q + 1'b1;
            out_data <= mem_q[rd_q];
            out_valid <= 1'b1;
         end else if (out_ready) begin
            out_valid <= 1'b0;
         end
      end
   end
endmodule : rbt_fifo

// file: core/rbt_path.sv
// one direction: transparent latch or edge register, gated capture, output enable
// assumes capture clock and controls are sampled synchronously on mclk
module rbt_path (
   // clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // source word and controls
   input wire logic [rbt_pkg::RBT_W-1:0] din,
   input wire logic transparent_en,
   input wire logic capture_clk,
   input wire logic clk_gate_n,
   input wire logic output_enable_n,
   // registered word and enable, combinational capture strobe
   output logic [rbt_pkg::RBT_W-1:0] dout_q,
   output logic oe_q,
   output logic cap_stb
);
   import rbt_pkg::*;
   logic cap_prev_q;
   logic [RBT_W-1:0] store_q;
   wire cap_rise = capture_clk & ~cap_prev_q; // RL8
   assign cap_stb = cap_rise & ~clk_gate_n & ~transparent_en; // RL4 RL7
   wire latch_open = transparent_en | cap_stb;
   wire [RBT_W-1:0] store_d = latch_open ? din : store_q; // RL3
   wire [RBT_W-1:0] dout_d = transparent_en ? din : store_d; // RL2 RL1

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cap_prev_q <= RBT_CAP_PREV_RST;
         store_q <= RBT_WORD_RST;
         dout_q <= RBT_WORD_RST;
         oe_q <= RBT_OE_RST;
      end else begin
         cap_prev_q <= capture_clk;
         store_q <= store_d; // RL11
         dout_q <= dout_d;
         oe_q <= ~output_enable_n; // RL5 RL6
      end
   end
endmodule : rbt_path

// file: verif/rbt_bus_model.sv
// external bus logic and the resolved wire of one data port
// assumes hold is the keeper level that the core presents for this port
module rbt_bus_model (
   // drivers of the wire
   input wire logic ext_en,
   input wire logic [rbt_pkg::RBT_W-1:0] ext_word,
   input wire logic core_oe,
   input wire logic [rbt_pkg::RBT_W-1:0] core_word,
   input wire logic [rbt_pkg::RBT_W-1:0] hold,
   // resolved wire
   output logic [rbt_pkg::RBT_W-1:0] level
);
   timeunit 1ns;
   timeprecision 1ns;
   import rbt_pkg::*;
   // released wire reads opposite to the keeper, so only bus hold restores it
   assign level = ext_en ? ext_word : core_oe ? core_word : ~hold;
endmodule : rbt_bus_model

// file: verif/registered_bus_transceiver_18b_bench.sv
// self-checking bench for the registered bus transceiver core
// assumes one 20 MHz clock; inputs change at the falling edge
module registered_bus_transceiver_18b_bench;
   timeunit 1ns;
   timeprecision 1ns;
   import rbt_pkg::*;
   logic mclk, rst_n, ea, eb, rdy, aoe, boe, cv, cfr, pab, pba, eaoe, eboe;
   logic [7:0] c;
   logic [RBT_W-1:0] wa, wb, ai, bi, ao, bo, ah, bh, cw, sa, sb, eah, ebh, fa, fb;
   logic [RBT_W-1:0] q[$];
   logic [31:0] rs;
   logic [7:0] am[5] = '{8'hff, 8'h77, 8'h22, 8'h02, 8'hff};
   logic [7:0] om[5] = '{8'h00, 8'h44, 8'h11, 8'h00, 8'h88};
   int num_errors = 0;
   int n_tests = 0;
   rbt_top dut (.mclk(mclk), .rst_n(rst_n),
      .a_side_bit_i(ai), .a_side_bit_o(ao), .a_side_bit_oe(aoe), .a_side_ext_drive(ea),
      .a_side_hold(ah), .b_side_bit_i(bi), .b_side_bit_o(bo), .b_side_bit_oe(boe),
      .b_side_ext_drive(eb), .b_side_hold(bh), .a_to_b_output_enable_n(c[7]),
      .a_to_b_transparent_en(c[6]), .a_to_b_capture_clk(c[5]), .a_to_b_clk_gate_n(c[4]),
      .b_to_a_output_enable_n(c[3]), .b_to_a_transparent_en(c[2]),
      .b_to_a_capture_clk(c[1]), .b_to_a_clk_gate_n(c[0]), .ab_cap_word(cw),
      .ab_cap_valid(cv), .ab_cap_ready(rdy), .ab_cap_fifo_ready(cfr));
   rbt_bus_model port_a (.ext_en(ea), .ext_word(wa), .core_oe(aoe), .core_word(ao),
      .hold(ah), .level(ai));
   rbt_bus_model port_b (.ext_en(eb), .ext_word(wb), .core_oe(boe), .core_word(bo),
      .hold(bh), .level(bi));
   function automatic logic [31:0] rnd();
      rs = rs ^ (rs << 13);
      rs = rs ^ (rs >> 17);
      rs = rs ^ (rs << 5);
      return rs;
   endfunction : rnd
   // next stored word: transparent load or gated rising capture
   function automatic logic [RBT_W-1:0] nxt(input logic [RBT_W-1:0] s, d,
      input logic te, ck, pv, g);
      return (te | (ck & !pv & !g)) ? d : s;
   endfunction : nxt
   task automatic check(input logic [RBT_W-1:0] seen, exp);
      n_tests++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
   endtask : check
   task finish_test();
      $display("checks %0d errors %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : finish_test
   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end
   // reference model of both paths and the capture log
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         sa = '0;
         sb = '0;
         eah = '0;
         ebh = '0;
         pab = 1'b1;
         pba = 1'b1;
         eaoe = 1'b0;
         eboe = 1'b0;
         q.delete();
      end else begin
         // an undriven wire counts as the keeper level
         fa = (ea || eaoe) ? ai : eah;
         fb = (eb || eboe) ? bi : ebh;
         if (cv && rdy) check(cw, q.pop_front());
         if (cfr && !c[6] && c[5] && !pab && !c[4]) q.push_back(fa);
         sb = nxt(sb, fa, c[6], c[5], pab, c[4]);
         sa = nxt(sa, fb, c[2], c[1], pba, c[0]);
         pab = c[5];
         pba = c[1];
         eboe = !c[7];
         eaoe = !c[3];
         eah = fa;
         ebh = fb;
      end
   end
   always @(negedge mclk) begin
      if (rst_n) begin
         check({17'h0, boe}, {17'h0, eboe});
         check({17'h0, aoe}, {17'h0, eaoe});
         if (eboe) check(bo, sb);
         if (eaoe) check(ao, sa);
         check(ah, eah);
         check(bh, ebh);
      end
   end
   initial begin
      #(RBT_CLK_PERIOD_NS * 1000.0);
      num_errors++;
      finish_test();
   end
   initial begin
      logic [31:0] r;
      c = 8'h88;
      ea = 1'b0;
      eb = 1'b0;
      rdy = 1'b0;
      wa = '0;
      wb = '0;
      rst_n = 1'b0;
      rs = 32'h19;
      repeat (8) @(posedge mclk);
      @(negedge mclk) rst_n = 1'b1;
      // random, transparent, gated, capture with log stalled, outputs off
      for (int t = 0; t < 5; t++) begin
         for (int i = 0; i < 60; i++) begin
            @(negedge mclk);
            r = rnd();
            // the log test toggles the a to b clock so the log surely fills
            c = ((r[7:0] & am[t]) | om[t]) ^ ((t == 3 && i[0]) ? 8'h20 : 8'h00);
            ea = c[3] & r[8];
            eb = c[7] & r[9];
            rdy = (t == 3) ? 1'b0 : r[10];
            r = rnd();
            wa = r[RBT_W-1:0];
            r = rnd();
            wb = r[RBT_W-1:0];
         end
         if (t == 3) begin
            check({17'h0, cfr}, 18'h0);
            check({17'h0, cv}, 18'h1);
         end
         $display("test %0d done", t);
      end
      finish_test();
   end
endmodule : registered_bus_transceiver_18b_bench
